// ---- rtl/cdm_consts.svh ----
// Purpose: constants of the core clock duty modulator
// Assumes: 100 MHz clock, one microsecond modulation tick
// Notes: included by the design module only
// Operation
// - period register bits 2:0 give a period of two to that power, microseconds
// - periods 2 to 128 microseconds only; default period is 32
// - on slice is period >> duty; off slice is period >> (8 - duty)
// - thermal fallback throttle forces a fixed 37.5% duty
// - priority: thermal fallback, then legacy package duty, then thread requests
// - thread requests modulate only when both thread enables are set
// - selected duty is latched at each period start
// - changes during a period wait until that whole period has finished
// - duty codes are three bits; code zero acts as 50%
// - thread duty is the larger code, sampled only when idle
// - one package-wide legacy register; the last write wins
`ifndef CDM_CONSTS_SVH
`define CDM_CONSTS_SVH
`define CDM_PERIOD_OFS 12'h276
`define CDM_PERIOD_MSB 2
`define CDM_PERIOD_RST 3'h5
`define CDM_PERIOD_MIN 3'h1
`define CDM_REQ_EN_BIT 4
`define CDM_REQ_DUTY_MSB 3
`define CDM_REQ_DUTY_LSB 1
`define CDM_THERMAL_DUTY 3'h3
`define CDM_ZERO_DUTY 3'h4
`define CDM_DUTY_SPAN 4'h8
`define CDM_CLK_NS 10
`define CDM_TICK_NS 1000
`define CDM_TICK_CYCLES ((`CDM_TICK_NS + `CDM_CLK_NS - 1) / `CDM_CLK_NS)
`endif

// ---- rtl/cdm_core_clock_duty_modulator.sv ----
// Purpose: per-core clock duty modulation with period, priority and slice timing
// Assumes: inputs synchronous to clk_in; request words hold enable bit 4, duty 3:1
// Notes: gate_en_out high lets the core clock run
`timescale 1ns/1ps
`include "cdm_consts.svh"
module cdm_core_clock_duty_modulator
  import cdm_pkg::*;
#(
  parameter int TICK_CYCLES = `CDM_TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [63:0] reg_wdata_in,
  output logic [63:0] reg_rdata_out,
  input wire logic pkg_wr_in,
  input wire logic [31:0] pkg_wdata_in,
  input wire logic [31:0] thr0_req_in,
  input wire logic [31:0] thr1_req_in,
  input wire logic thermal_in,
  output logic gate_en_out,
  output logic modulating_out,
  output logic [2:0] duty_out
);
  // refuse tick divisors that the seven-bit tick counter cannot hold
  if (TICK_CYCLES < 1 || TICK_CYCLES > 128) begin : g_tick_range
    $error("TICK_CYCLES out of range");
  end

  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

  cdm_state_t state_r, state_nxt;
  logic [6:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  logic [2:0] per_code_r, per_code_nxt;
  logic [63:0] rdata_r, rdata_nxt;
  logic leg_en_r, leg_en_nxt;
  logic [2:0] leg_duty_r, leg_duty_nxt;
  logic [2:0] duty_r, duty_nxt;
  logic [2:0] per_lat_r, per_lat_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic gate_r, gate_nxt;
  logic [2:0] code_eff, lat_eff, d0, d1, leg_d, thr_d, sel_duty;
  logic engaged;
  logic [7:0] cand_on, cand_off, cur_off;

  // zero duty behaves as 50%
  function automatic logic [2:0] fix_duty(input logic [2:0] d);
    fix_duty = (d == 3'h0) ? `CDM_ZERO_DUTY : d;
  endfunction

  // unsupported code 0 would give 1 us, so it is served as the 2 us minimum
  function automatic logic [7:0] per_len(input logic [2:0] c);
    logic [2:0] ce;
    ce = (c < `CDM_PERIOD_MIN) ? `CDM_PERIOD_MIN : c;
    per_len = 8'(8'h01 << ce);
  endfunction

  // microsecond tick from the uncore clock
  always_comb begin
    tick = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick ? 7'h00 : 7'(tick_cnt_r + 7'h01);
  end

  // period register and package legacy register
  always_comb begin
    per_code_nxt = per_code_r;
    leg_en_nxt = leg_en_r;
    leg_duty_nxt = leg_duty_r;
    rdata_nxt = rdata_r;
    if (reg_wr_in && reg_addr_in == `CDM_PERIOD_OFS) begin
      per_code_nxt = reg_wdata_in[`CDM_PERIOD_MSB:0];
    end
    // one shared copy; whichever core writes last owns it
    if (pkg_wr_in) begin
      leg_en_nxt = pkg_wdata_in[`CDM_REQ_EN_BIT];
      leg_duty_nxt = pkg_wdata_in[`CDM_REQ_DUTY_MSB:`CDM_REQ_DUTY_LSB];
    end
    // unmapped reads return zero
    if (reg_rd_in) begin
      rdata_nxt = (reg_addr_in == `CDM_PERIOD_OFS) ? {61'h0, per_code_r} : 64'h0;
    end
  end

  // duty selection by fixed priority
  always_comb begin
    d0 = fix_duty(thr0_req_in[`CDM_REQ_DUTY_MSB:`CDM_REQ_DUTY_LSB]);
    d1 = fix_duty(thr1_req_in[`CDM_REQ_DUTY_MSB:`CDM_REQ_DUTY_LSB]);
    thr_d = (d0 > d1) ? d0 : d1;
    leg_d = fix_duty(leg_duty_r);
    code_eff = per_code_r;
    lat_eff = per_lat_r;
    if (thermal_in) begin
      sel_duty = `CDM_THERMAL_DUTY;
    end else if (leg_en_r) begin
      sel_duty = leg_d;
    end else begin
      sel_duty = thr_d;
    end
    engaged = thermal_in || leg_en_r ||
      (thr0_req_in[`CDM_REQ_EN_BIT] && thr1_req_in[`CDM_REQ_EN_BIT]);
    cand_on = per_len(code_eff) >> sel_duty;
    cand_off = per_len(code_eff) >> (`CDM_DUTY_SPAN - {1'b0, sel_duty});
    cur_off = per_len(lat_eff) >> (`CDM_DUTY_SPAN - {1'b0, duty_r});
  end

  // modulation state machine; inputs are looked at only at period starts
  always_comb begin
    state_nxt = state_r;
    duty_nxt = duty_r;
    per_lat_nxt = per_lat_r;
    cnt_nxt = cnt_r;
    case (state_r)
      CDM_IDLE: begin
        if (tick && engaged) begin
          duty_nxt = sel_duty;
          per_lat_nxt = code_eff;
          if (cand_on != 8'h00) begin
            state_nxt = CDM_ON;
            cnt_nxt = 8'(cand_on - 8'h01);
          end else if (cand_off != 8'h00) begin
            state_nxt = CDM_OFF;
            cnt_nxt = 8'(cand_off - 8'h01);
          end
        end
      end
      CDM_ON: begin
        if (tick) begin
          if (cnt_r != 8'h00) begin
            cnt_nxt = 8'(cnt_r - 8'h01);
          end else if (cur_off != 8'h00) begin
            state_nxt = CDM_OFF;
            cnt_nxt = 8'(cur_off - 8'h01);
          end else begin
            state_nxt = CDM_IDLE;
          end
        end
      end
      CDM_OFF: begin
        // back through idle so the next period reloads the duty
        if (tick) begin
          if (cnt_r != 8'h00) begin
            cnt_nxt = 8'(cnt_r - 8'h01);
          end else begin
            state_nxt = CDM_IDLE;
          end
        end
      end
      default: begin
        state_nxt = CDM_IDLE;
      end
    endcase
    gate_nxt = (state_nxt != CDM_OFF);
  end

  // registers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= CDM_IDLE;
      tick_cnt_r <= 7'h00;
      per_code_r <= `CDM_PERIOD_RST;
      rdata_r <= 64'h0;
      leg_en_r <= 1'b0;
      leg_duty_r <= 3'h0;
      duty_r <= 3'h0;
      per_lat_r <= `CDM_PERIOD_RST;
      cnt_r <= 8'h00;
      gate_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      per_code_r <= per_code_nxt;
      rdata_r <= rdata_nxt;
      leg_en_r <= leg_en_nxt;
      leg_duty_r <= leg_duty_nxt;
      duty_r <= duty_nxt;
      per_lat_r <= per_lat_nxt;
      cnt_r <= cnt_nxt;
      gate_r <= gate_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign gate_en_out = gate_r;
  assign modulating_out = (state_r != CDM_IDLE);
  assign duty_out = duty_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  period_write_a: assert property (
    reg_wr_in && reg_addr_in == `CDM_PERIOD_OFS && !reg_rd_in ##1 reg_rd_in &&
    reg_addr_in == `CDM_PERIOD_OFS |=> reg_rdata_out[2:0] == $past(reg_wdata_in[2:0], 2))
    else $error("period code not read back");
  period_reset_a: assert property ($rose(resetn_in) |-> per_code_r == 3'h5)
    else $error("period code not five after reset");
  thermal_duty_a: assert property (
    state_r == CDM_IDLE && tick && thermal_in |=> duty_r == 3'h3 &&
    (state_r != CDM_IDLE || ($past(cand_on) == 8'h00 && $past(cand_off) == 8'h00)))
    else $error("thermal fallback duty not applied");
  legacy_prio_a: assert property (
    state_r == CDM_IDLE && tick && !thermal_in && leg_en_r |=>
    duty_r == (($past(leg_duty_r) == 3'h0) ? 3'h4 : $past(leg_duty_r)))
    else $error("legacy duty not selected");
  thread_both_a: assert property (
    state_r == CDM_IDLE && tick && !thermal_in && !leg_en_r &&
    !(thr0_req_in[4] && thr1_req_in[4]) |=> state_r == CDM_IDLE && gate_en_out)
    else $error("modulation without both thread enables");
  thread_max_a: assert property (
    state_r == CDM_IDLE && tick && !thermal_in && !leg_en_r && engaged |=>
    duty_r >= $past(d0) && duty_r >= $past(d1))
    else $error("thread duty not the larger code");
  slice_hold_a: assert property (
    state_r != CDM_IDLE ##1 state_r != CDM_IDLE |-> $stable(duty_r) && $stable(per_lat_r))
    else $error("duty changed inside a period");
  on_length_a: assert property (
    state_r == CDM_IDLE && tick && engaged && cand_on != 8'h00 |=>
    state_r == CDM_ON && cnt_r == 8'($past(cand_on) - 8'h01))
    else $error("on slice length wrong");
  off_gate_a: assert property (
    state_r == CDM_ON && tick && cnt_r == 8'h00 && cur_off != 8'h00 |=>
    !gate_en_out && state_r == CDM_OFF && cnt_r == 8'($past(cur_off) - 8'h01))
    else $error("clock not gated in off slice");
  zero_duty_a: assert property (
    state_r == CDM_IDLE && tick && !thermal_in && leg_en_r && leg_duty_r == 3'h0 |=>
    duty_r == 3'h4)
    else $error("zero duty not served as half");
  legacy_write_a: assert property (pkg_wr_in |=> leg_en_r == $past(pkg_wdata_in[4]))
    else $error("legacy enable not stored");

  thermal_run_c: cover property (thermal_in && state_r == CDM_OFF);
  legacy_run_c: cover property (leg_en_r && !thermal_in && state_r == CDM_OFF);
  thread_run_c: cover property (!leg_en_r && !thermal_in && state_r == CDM_ON);
  period_reload_c: cover property (state_r == CDM_OFF ##1 state_r == CDM_IDLE ##1
    state_r == CDM_ON);
endmodule

// ---- rtl/cdm_pkg.sv ----
// Purpose: types of the core clock duty modulator
// Assumes: nothing beyond the constants header
// Notes: state codes written out
package cdm_pkg;
  typedef enum logic [1:0] {
    CDM_IDLE = 2'b00,
    CDM_ON = 2'b01,
    CDM_OFF = 2'b10
  } cdm_state_t;
endpackage

// ---- verification/cdm_core_clock_duty_modulator_tb.sv ----
// Purpose: self-checking bench for the core clock duty modulator
// Assumes: tick shortened to 4 clocks per microsecond
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module cdm_core_clock_duty_modulator_tb;
  localparam int TK = 4;
  logic clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic pkg_wr_in = 1'b0, thermal_in = 1'b0, m_wr = 1'b0, m_sel = 1'b0;
  logic [11:0] reg_addr_in = 12'h0;
  logic [63:0] reg_wdata_in = 64'h0, reg_rdata_out;
  logic [31:0] pkg_wdata_in = 32'h0, thr0, thr1;
  logic [15:0] off_cnt, off_base;
  logic gate_en_out, modulating_out;
  logic [2:0] duty_out;
  int n_errors = 0, comparisons = 0;
  always #5 clk_in = ~clk_in;
  cdm_core_clock_duty_modulator #(.TICK_CYCLES(TK)) cdm_core_clock_duty_modulator_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .pkg_wr_in(pkg_wr_in), .pkg_wdata_in(pkg_wdata_in), .thr0_req_in(thr0),
    .thr1_req_in(thr1), .thermal_in(thermal_in), .gate_en_out(gate_en_out),
    .modulating_out(modulating_out), .duty_out(duty_out));
  cdm_core_model cdm_core_model_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .gate_en_in(gate_en_out), .wr_in(m_wr), .sel_in(m_sel), .wdata_in(pkg_wdata_in),
    .thr0_req_out(thr0), .thr1_req_out(thr1), .off_cnt_out(off_cnt));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one-cycle register strobe; read data holds until the next read
  task automatic reg_op(input logic wr, input logic [11:0] a, input logic [2:0] d);
    reg_addr_in = a;
    reg_wdata_in = {61'h0, d};
    reg_wr_in = wr;
    reg_rd_in = !wr;
    cyc(1);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    cyc(1);
  endtask
  // w 0/1 writes a thread word, 2 the package word
  task automatic req(input int w, input logic en, input logic [2:0] d);
    pkg_wdata_in = {27'h0, en, d, 1'b0};
    m_sel = (w == 1);
    pkg_wr_in = (w == 2);
    m_wr = (w != 2);
    cyc(1);
    pkg_wr_in = 1'b0;
    m_wr = 1'b0;
    cyc(1);
  endtask
  task automatic wait_mod(input logic lvl);
    int i;
    i = 0;
    while (modulating_out !== lvl && i < 400) begin
      cyc(1);
      i++;
    end
    if (i == 400) check(1'b0, 1'b1);
  endtask
  // a period may already run when a source drops, so let it finish
  task automatic quiet();
    cyc(1);
    wait_mod(1'b0);
  endtask
  // one whole period: latched duty, then gated clocks since off_base
  task automatic period(input logic [2:0] d, input logic [63:0] off);
    wait_mod(1'b1);
    check(duty_out, d);
    wait_mod(1'b0);
    cyc(2);
    check(off_cnt - off_base, off);
  endtask
  task automatic t_reset();
    check(gate_en_out, 1'b1);
    check(modulating_out, 1'b0);
    reg_op(1'b0, 12'h276, 3'h0);
    check(reg_rdata_out, 64'h5);
    $display("reset test done");
  endtask
  task automatic t_regs();
    reg_op(1'b1, 12'h276, 3'h3);
    reg_op(1'b0, 12'h276, 3'h0);
    check(reg_rdata_out, 64'h3);
    reg_op(1'b1, 12'h277, 3'h7);
    reg_op(1'b0, 12'h277, 3'h0);
    check(reg_rdata_out, 64'h0);
    // write, then read on the very next edge: the read already sees the new code
    reg_addr_in = 12'h276;
    reg_wdata_in = 64'h5;
    reg_wr_in = 1'b1;
    cyc(1);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b1;
    cyc(1);
    reg_rd_in = 1'b0;
    cyc(1);
    check(reg_rdata_out, 64'h5);
    $display("register test done");
  endtask
  // fixed duty 3 at 32 us: off slice is one tick
  task automatic t_thermal();
    off_base = off_cnt;
    thermal_in = 1'b1;
    period(3'h3, 64'(1 * TK));
    thermal_in = 1'b0;
    quiet();
    $display("thermal test done");
  endtask
  // 128 us period; duty change in mid-period waits for the next one
  task automatic t_legacy();
    reg_op(1'b1, 12'h276, 3'h7);
    off_base = off_cnt;
    req(2, 1'b1, 3'h6);
    period(3'h6, 64'(32 * TK));
    wait_mod(1'b1);
    req(2, 1'b1, 3'h0);
    check(duty_out, 3'h6);
    wait_mod(1'b0);
    off_base = off_cnt;
    period(3'h4, 64'(8 * TK));
    req(2, 1'b0, 3'h0);
    quiet();
    reg_op(1'b1, 12'h276, 3'h5);
    $display("legacy test done");
  endtask
  task automatic t_threads();
    req(0, 1'b1, 3'h2);
    cyc(4 * TK);
    check(modulating_out, 1'b0);
    off_base = off_cnt;
    req(1, 1'b1, 3'h5);
    period(3'h5, 64'(4 * TK));
    req(0, 1'b0, 3'h0);
    quiet();
    $display("thread test done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(5);
    resetn_in = 1'b1;
    t_reset();
    t_regs();
    t_thermal();
    t_legacy();
    t_threads();
    close_out();
  end
  // tests need well under a thousand cycles; this is far beyond
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule

// ---- verification/cdm_core_model.sv ----
// Purpose: core-side model of thread request words and the gated core clock
// Assumes: software writes each request word whole
// Notes: off_cnt_out counts clocks with the core clock gated
`timescale 1ns/1ps
module cdm_core_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic gate_en_in,
  input wire logic wr_in,
  input wire logic sel_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] thr0_req_out,
  output logic [31:0] thr1_req_out,
  output logic [15:0] off_cnt_out
);
  // duty codes come only from software writes, never set here
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      thr0_req_out <= 32'h0;
      thr1_req_out <= 32'h0;
      off_cnt_out <= 16'h0;
    end else begin
      if (wr_in && !sel_in) thr0_req_out <= wdata_in;
      if (wr_in && sel_in) thr1_req_out <= wdata_in;
      off_cnt_out <= off_cnt_out + {15'h0, !gate_en_in};
    end
  end
endmodule
